// ---- rtl/eeprom_spi_pkg.sv ----
// constants, codes and carriers for the serial eeprom command logic
// assumes a 100 MHz system clock and a host-driven serial clock
package eeprom_spi_pkg;

  localparam int ADDR_W    = 15;
  localparam int ID_W      = 6;
  localparam int MEM_DEPTH = 32768;
  localparam int ID_DEPTH  = 64;

  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ   = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ    = 8'h03;

  // status bit positions
  localparam int ST_BUSY       = 0;
  localparam int ST_WRITE_LATCH = 1;
  localparam int ST_BLOCK_LOW  = 2;
  localparam int ST_BLOCK_HIGH = 3;
  localparam int ST_PAGE_LOCK  = 4;
  localparam int ST_PAGE_SEL   = 6;
  localparam int ST_PIN_ENABLE = 7;

  localparam logic [7:0] ST_RESET_VAL     = 8'h00;
  localparam logic [7:0] LEGACY_BUSY_BYTE = 8'hFF;

  // serial clock counts within one selection
  localparam logic [4:0] CMD_BITS      = 5'h08;
  localparam logic [4:0] SWRITE_BITS   = 5'h10;
  localparam logic [4:0] READ_HDR_BITS = 5'h18;
  localparam logic [4:0] TOT_MAX       = 5'h1F;

  // self-timed write cycle
  localparam int T_WRITE_NS    = 5000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WR_CYCLES     = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CNT_W      = 10;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_WRITE_ENABLE,
    CMD_WRITE_DISABLE,
    CMD_STATUS_WRITE,
    CMD_ARRAY_READ,
    CMD_STATUS_READ,
    CMD_OTHER
  } cmd_e;

  typedef enum logic [2:0] {
    LS_CMD,
    LS_ADDR,
    LS_READ,
    LS_STAT,
    LS_SWRITE,
    LS_IGNORE
  } link_state_e;

  typedef struct packed {
    logic              valid;
    logic              id_page;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } load_s;

  // summary of one selection, quasi-static once chip select is high
  typedef struct packed {
    logic       tog;
    cmd_e       kind;
    logic [4:0] bits;
    logic [7:0] data;
    logic       rd_done;
  } frame_s;

endpackage

// ---- rtl/spi_eeprom_status_read_hold.sv ----
// serial eeprom slave: command decode, reads, status write and hold pause
// assumes sck is a clock port of its own and the array is loaded over i_load
//
// Contract
// R1 - status write changes only bits 2,3,4,6,7
// R2 - pin low with pin-enable set blocks status write
// R3 - pin falling during selection aborts status write
// R4 - started write cycle ignores the pin
// R5 - pin-enable clear means pin ignored
// R6 - host sends read code then 16-bit address
// R7 - stream data, advance pointer, wrap top to bottom
// R8 - chip select high ends read, output stops
// R9 - host sets page select before page read
// R10 - page read uses six-bit wrapping pointer
// R11 - host stays within the 64-byte page
// R12 - status read shifts status, accepted any time
// R13 - full status while busy, legacy gives FFh
// R14 - after busy clears status reads correct
// R15 - host asserts hold only with clock low
// R16 - hold floats output, freezes transfer state
// R17 - host releases hold only with clock low
// R18 - reset: standby, latch clear, no write
// R19 - host selects device before first instruction
// R20 - exact clock count launches write, latch clears
// R21 - array access ignored while write cycle runs
// R22 - unknown code: no action, output floats
// R23 - busy flag high throughout write cycle
// R24 - latch set by enable, cleared by disable
// R25 - page select clears after completed operation
// R26 - sample input rising, drive output falling
`timescale 1ns/10ps

module spi_eeprom_status_read_hold #(
  parameter logic [7:0] P_WRITE_ENABLE_OP = 8'h06,
  parameter bit         P_LEGACY_REV      = 1'b0
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rstn,
  input  wire logic                  i_sck,
  input  wire logic                  i_cs_n,
  input  wire logic                  i_si,
  input  wire logic                  i_hold_n,
  input  wire logic                  i_wp_n,
  input  wire eeprom_spi_pkg::load_s i_load,
  output logic                       o_so,
  output logic                       o_so_oe,
  output logic                       o_busy,
  output logic [7:0]                 o_status
);
  import eeprom_spi_pkg::*;

  logic [7:0]          mem_array [MEM_DEPTH];
  logic [7:0]          id_array  [ID_DEPTH];

  // system domain
  logic                cs_meta_ff;
  logic                cs_sync_ff;
  logic                cs_prev_ff;
  logic                wp_meta_ff;
  logic                wp_sync_ff;
  logic                wp_prev_ff;
  frame_s              frame_meta_ff;
  frame_s              frame_sync_ff;
  logic                eval_ff;
  logic                seen_tog_ff;
  logic                wp_fell_ff;
  logic [7:0]          status_ff;
  logic [7:0]          pend_ff;
  logic [WR_CNT_W-1:0] wr_cnt_ff;
  logic                frame_new;
  logic                hw_protect;
  logic                do_wen;
  logic                do_wdis;
  logic                do_swrite;
  logic                do_rd_end;
  logic                wr_done;

  // link domain
  logic [7:0]          stat_meta_ff;
  logic [7:0]          stat_sync_ff;
  link_state_e         st_ff;
  logic [4:0]          tot_ff;
  logic [15:0]         sh_ff;
  logic [ADDR_W-1:0]   ptr_ff;
  logic [2:0]          oidx_ff;
  frame_s              frame_ff;
  logic                so_ff;
  logic                oact_ff;
  logic [7:0]          code;
  link_state_e         cmd_state;
  cmd_e                cmd_kind;
  logic                busy_l;
  logic                page_l;
  logic [7:0]          rd_byte;
  logic [7:0]          stat_out;
  logic [4:0]          tot_inc;

  // backdoor programming of the cell arrays; stands in for the write path
  always_ff @(posedge i_clk) begin
    if (i_load.valid) begin
      if (i_load.id_page) begin
        id_array[i_load.addr[ID_W-1:0]] <= i_load.data;
      end else begin
        mem_array[i_load.addr] <= i_load.data;
      end
    end
  end

  // pin and frame synchronisers
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cs_meta_ff <= 1'b1;
      cs_sync_ff <= 1'b1;
      cs_prev_ff <= 1'b1;
      wp_meta_ff <= 1'b1;
      wp_sync_ff <= 1'b1;
      wp_prev_ff <= 1'b1;
    end else begin
      cs_meta_ff <= i_cs_n;
      cs_sync_ff <= cs_meta_ff;
      cs_prev_ff <= cs_sync_ff;
      wp_meta_ff <= i_wp_n;
      wp_sync_ff <= wp_meta_ff;
      wp_prev_ff <= wp_sync_ff;
    end
  end

  // the summary settles before chip select rises, so two stages plus eval suffice
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      frame_meta_ff <= '0;
      frame_sync_ff <= '0;
      eval_ff       <= 1'b0;
      seen_tog_ff   <= 1'b0;
    end else begin
      frame_meta_ff <= frame_ff;
      frame_sync_ff <= frame_meta_ff;
      eval_ff       <= cs_sync_ff & ~cs_prev_ff;
      if (eval_ff) begin
        seen_tog_ff <= frame_sync_ff.tog;
      end
    end
  end

  assign frame_new  = eval_ff && (frame_sync_ff.tog != seen_tog_ff);
  assign hw_protect = status_ff[ST_PIN_ENABLE] && !wp_sync_ff; // R2 R5
  assign wr_done    = status_ff[ST_BUSY] && (wr_cnt_ff == '0);

  always_comb begin
    do_wen    = frame_new && !status_ff[ST_BUSY] && (frame_sync_ff.bits == CMD_BITS)
                && (frame_sync_ff.kind == CMD_WRITE_ENABLE);
    do_wdis   = frame_new && !status_ff[ST_BUSY] && (frame_sync_ff.bits == CMD_BITS)
                && (frame_sync_ff.kind == CMD_WRITE_DISABLE);
    do_swrite = frame_new && !status_ff[ST_BUSY] && (frame_sync_ff.bits == SWRITE_BITS) // R20
                && (frame_sync_ff.kind == CMD_STATUS_WRITE)
                && status_ff[ST_WRITE_LATCH] && !hw_protect && !wp_fell_ff; // R2 R3
    do_rd_end = frame_new && !status_ff[ST_BUSY] && frame_sync_ff.rd_done
                && (frame_sync_ff.kind == CMD_ARRAY_READ);
  end

  // a pin fall inside a selection aborts the pending status write; set beats clear
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wp_fell_ff <= 1'b0;
    end else if (!cs_sync_ff && wp_prev_ff && !wp_sync_ff && status_ff[ST_PIN_ENABLE]) begin
      wp_fell_ff <= 1'b1; // R3 R5
    end else if (!cs_sync_ff && cs_prev_ff) begin
      wp_fell_ff <= 1'b0;
    end
  end

  // data is latched at launch so nothing on the pin reaches it afterwards
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pend_ff <= ST_RESET_VAL;
    end else if (do_swrite) begin
      pend_ff <= frame_sync_ff.data; // R4
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      wr_cnt_ff <= '0;
    end else if (do_swrite) begin
      wr_cnt_ff <= WR_CNT_W'(WR_CYCLES - 1);
    end else if (status_ff[ST_BUSY] && (wr_cnt_ff != '0)) begin
      wr_cnt_ff <= wr_cnt_ff - WR_CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      status_ff <= ST_RESET_VAL; // R18
    end else begin
      if (do_swrite) begin
        status_ff[ST_BUSY] <= 1'b1; // R23
      end else if (wr_done) begin
        status_ff[ST_BUSY] <= 1'b0; // R23
      end
      if (do_wen) begin
        status_ff[ST_WRITE_LATCH] <= 1'b1; // R24
      end else if (do_wdis || wr_done) begin
        status_ff[ST_WRITE_LATCH] <= 1'b0; // R20 R24
      end
      if (wr_done) begin
        status_ff[ST_PIN_ENABLE] <= pend_ff[ST_PIN_ENABLE]; // R1
        status_ff[ST_BLOCK_HIGH] <= pend_ff[ST_BLOCK_HIGH];
        status_ff[ST_BLOCK_LOW]  <= pend_ff[ST_BLOCK_LOW];
        // asking for page select and lock together leaves both untouched
        if (!(pend_ff[ST_PAGE_SEL] && pend_ff[ST_PAGE_LOCK])) begin
          status_ff[ST_PAGE_SEL]  <= pend_ff[ST_PAGE_SEL];
          status_ff[ST_PAGE_LOCK] <= status_ff[ST_PAGE_LOCK] | pend_ff[ST_PAGE_LOCK];
        end
      end else if (do_rd_end) begin
        status_ff[ST_PAGE_SEL] <= 1'b0; // R25
      end
    end
  end

  assign o_status = status_ff;
  assign o_busy   = status_ff[ST_BUSY];

  // status is quasi-static across a selection; the first two command clocks fill the pipe
  always_ff @(posedge i_sck or negedge i_rstn) begin
    if (!i_rstn) begin
      stat_meta_ff <= ST_RESET_VAL;
      stat_sync_ff <= ST_RESET_VAL;
    end else begin
      stat_meta_ff <= status_ff;
      stat_sync_ff <= stat_meta_ff;
    end
  end

  assign busy_l  = stat_sync_ff[ST_BUSY];
  assign page_l  = stat_sync_ff[ST_PAGE_SEL];
  assign code    = {sh_ff[6:0], i_si};
  assign tot_inc = (tot_ff == TOT_MAX) ? TOT_MAX : tot_ff + 5'h01;

  always_comb begin
    case (code)
      OP_ARRAY_READ: begin
        cmd_kind  = CMD_ARRAY_READ;
        cmd_state = busy_l ? LS_IGNORE : LS_ADDR; // R21
      end
      OP_STATUS_READ: begin
        cmd_kind  = CMD_STATUS_READ;
        cmd_state = LS_STAT; // R12
      end
      OP_STATUS_WRITE: begin
        cmd_kind  = CMD_STATUS_WRITE;
        cmd_state = LS_SWRITE;
      end
      OP_WRITE_DISABLE: begin
        cmd_kind  = CMD_WRITE_DISABLE;
        cmd_state = LS_IGNORE;
      end
      P_WRITE_ENABLE_OP: begin
        cmd_kind  = CMD_WRITE_ENABLE;
        cmd_state = LS_IGNORE;
      end
      default: begin
        cmd_kind  = CMD_OTHER;
        cmd_state = LS_IGNORE; // R22
      end
    endcase
  end

  // deselect clears the transfer; the device is only ready once selected
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      st_ff   <= LS_CMD; // R8 R19
      tot_ff  <= '0;
      sh_ff   <= '0;
      ptr_ff  <= '0;
      oidx_ff <= '0;
    end else if (i_hold_n) begin // R15 R16 R17 R26
      tot_ff <= tot_inc;
      sh_ff  <= {sh_ff[14:0], i_si};
      case (st_ff)
        LS_CMD: begin
          if (tot_ff == CMD_BITS - 5'h01) begin
            st_ff <= cmd_state;
          end
        end
        LS_ADDR: begin
          if (tot_ff == READ_HDR_BITS - 5'h01) begin
            ptr_ff <= {sh_ff[13:0], i_si}; // R6
            st_ff  <= LS_READ;
          end
        end
        LS_READ: begin
          oidx_ff <= oidx_ff + 3'h1;
          if (oidx_ff == 3'h7) begin
            if (page_l) begin
              ptr_ff[ID_W-1:0] <= ptr_ff[ID_W-1:0] + 6'h01; // R9 R10 R11
            end else begin
              ptr_ff <= ptr_ff + 15'h0001; // R7
            end
          end
        end
        LS_STAT: oidx_ff <= oidx_ff + 3'h1;
        LS_SWRITE: begin
          if (tot_ff == SWRITE_BITS - 5'h01) begin
            st_ff <= LS_IGNORE;
          end
        end
        default: ;
      endcase
    end
  end

  // summary outlives the selection, so it is cleared only by system reset
  always_ff @(posedge i_sck or negedge i_rstn) begin
    if (!i_rstn) begin
      frame_ff <= '0;
    end else if (!i_cs_n && i_hold_n) begin
      frame_ff.bits <= tot_inc;
      if (tot_ff == '0) begin
        frame_ff.tog     <= ~frame_ff.tog;
        frame_ff.kind    <= CMD_NONE;
        frame_ff.rd_done <= 1'b0;
      end
      if (st_ff == LS_CMD && tot_ff == CMD_BITS - 5'h01) begin
        frame_ff.kind <= cmd_kind;
      end
      if (st_ff == LS_ADDR && tot_ff == READ_HDR_BITS - 5'h01) begin
        frame_ff.rd_done <= 1'b1;
      end
      if (st_ff == LS_SWRITE) begin
        frame_ff.data <= {sh_ff[6:0], i_si};
      end
    end
  end

  assign rd_byte  = page_l ? id_array[ptr_ff[ID_W-1:0]] : mem_array[ptr_ff];
  // legacy parts return FFh instead of the status byte while a write runs
  assign stat_out = (P_LEGACY_REV && busy_l) ? LEGACY_BUSY_BYTE : stat_sync_ff; // R13 R14

  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      so_ff   <= 1'b0; // R8
      oact_ff <= 1'b0;
    end else if (i_hold_n) begin // R16 R26
      case (st_ff)
        LS_READ: begin
          so_ff   <= rd_byte[3'h7 - oidx_ff]; // R7
          oact_ff <= 1'b1;
        end
        LS_STAT: begin
          so_ff   <= stat_out[3'h7 - oidx_ff]; // R12
          oact_ff <= 1'b1;
        end
        default: begin
          so_ff   <= 1'b0; // R22
          oact_ff <= 1'b0;
        end
      endcase
    end
  end

  assign o_so    = so_ff;
  assign o_so_oe = oact_ff & i_hold_n & ~i_cs_n; // R8 R16

endmodule // spi_eeprom_status_read_hold

// ---- tb/spi_eeprom_monitor.sv ----
// port assertions for the serial eeprom command block
// assumes it is bound to every instance of the block; all checks run on i_clk
`timescale 1ns/10ps

module spi_eeprom_monitor
  import eeprom_spi_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic       i_cs_n,
  input wire logic       i_hold_n,
  input wire logic       o_so_oe,
  input wire logic       o_busy,
  input wire logic [7:0] o_status
);
  default clocking dcb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  // length of the current busy run, cleared whenever busy is low
  logic [WR_CNT_W-1:0] busy_len_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rstn || !o_busy) begin
      busy_len_ff <= '0;
    end else begin
      busy_len_ff <= busy_len_ff + WR_CNT_W'(1);
    end
  end

  busy_mirror_a:
    assert property (o_busy == o_status[ST_BUSY]) else $error("busy differs from status bit");
  reset_clean_a:
    assert property ($rose(i_rstn) |-> o_status == ST_RESET_VAL && !o_so_oe)
    else $error("state not clean after reset");
  write_len_a:
    assert property ($fell(o_busy) |-> busy_len_ff >= WR_CYCLES && busy_len_ff <= WR_CYCLES + 1)
    else $error("write cycle length wrong");
  latch_drop_a:
    assert property ($fell(o_busy) |-> !o_status[ST_WRITE_LATCH])
    else $error("write latch still set after write");
  launch_cs_a:
    assert property ($rose(o_busy) |-> i_cs_n) else $error("write launched while selected");
  latch_idle_a:
    assert property ($rose(o_status[ST_WRITE_LATCH]) |-> !o_busy && i_cs_n)
    else $error("write latch set while busy or selected");
  prot_bits_a:
    assert property ($changed({o_status[7], o_status[4:2]}) |-> $fell(o_busy))
    else $error("protect bits moved outside write end");
  bit_five_a:
    assert property (o_status[5] == 1'b0) else $error("status bit 5 set");
  cs_off_a:
    assert property (i_cs_n |-> !o_so_oe) else $error("output driven while deselected");
  hold_off_a:
    assert property (!i_hold_n |-> !o_so_oe) else $error("output driven during pause");
endmodule // spi_eeprom_monitor

bind spi_eeprom_status_read_hold spi_eeprom_monitor u_monitor (
  .i_clk   (i_clk),
  .i_rstn  (i_rstn),
  .i_cs_n  (i_cs_n),
  .i_hold_n(i_hold_n),
  .o_so_oe (o_so_oe),
  .o_busy  (o_busy),
  .o_status(o_status)
);

// ---- tb/spi_host_model.sv ----
// serial host: mode 0 frames of whole bytes, 30 ns clock, optional pause
// assumes the bench calls frame() with chip select idle between calls
`timescale 1ns/10ps

module spi_host_model (
  input  wire logic i_so,
  input  wire logic i_so_oe,
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  output logic      o_hold_n
);
  logic so_last = 1'b0;
  logic oe_seen = 1'b0;
  logic hold_oe = 1'b0;

  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b0;
    o_si = 1'b0;
    o_hold_n = 1'b1;
    // a real rising edge clears the serial-side transfer state at start-up
    #1 o_cs_n = 1'b1;
  end

  // clock edges during the pause must be ignored, so si keeps moving
  task automatic pause();
    // hold moves clear of the sck fall so that fall still shifts its bit
    #5 o_hold_n = 1'b0;
    repeat (2) begin
      #15 o_sck = 1'b1;
      o_si = ~o_si;
      hold_oe |= i_so_oe;
      #15 o_sck = 1'b0;
    end
    #5 o_hold_n = 1'b1;
  endtask

  task automatic frame(input logic [7:0] tx[$], input int hold_at, output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    oe_seen = 1'b0;
    hold_oe = 1'b0;
    o_cs_n = 1'b0;
    #23;
    foreach (tx[k]) begin
      if (k == hold_at)
        pause();
      for (int i = 7; i >= 0; i--) begin
        o_si = tx[k][i];
        #15 o_sck = 1'b1;
        // an undriven line reads as the inverse of the last bit, never a lucky match
        b[i] = i_so_oe ? i_so : ~so_last;
        so_last = b[i];
        oe_seen |= i_so_oe;
        #15 o_sck = 1'b0;
      end
      rx.push_back(b);
    end
    #10 o_cs_n = 1'b1;
    o_si = ~o_si;
    #90;
  endtask
endmodule // spi_host_model

// ---- tb/testbench.sv ----
// self-checking bench for the serial eeprom command block
// assumes the host model owns the serial pins; wp and load move on falling i_clk
`timescale 1ns/10ps

module testbench;
  import eeprom_spi_pkg::*;
  localparam logic [7:0] ENABLE_OP = 8'h06;

  logic       i_clk;
  logic       i_rstn;
  logic       i_wp_n;
  load_s      i_load;
  logic       sck;
  logic       cs_n;
  logic       si;
  logic       hold_n;
  logic       so;
  logic       so_oe;
  logic       busy;
  logic [7:0] status;
  logic [7:0] rx[$];
  int         err_total = 0;
  int         checked = 0;

  spi_eeprom_status_read_hold #(.P_WRITE_ENABLE_OP(ENABLE_OP), .P_LEGACY_REV(1'b0)) DUT (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
    .i_hold_n(hold_n), .i_wp_n(i_wp_n), .i_load(i_load), .o_so(so),
    .o_so_oe(so_oe), .o_busy(busy), .o_status(status));

  spi_host_model host (.i_so(so), .i_so_oe(so_oe), .o_sck(sck), .o_cs_n(cs_n),
    .o_si(si), .o_hold_n(hold_n));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic stat_is(input logic [7:0] mask, input logic [7:0] exp);
    host.frame('{OP_STATUS_READ, 8'h00}, -1, rx);
    chk(rx[1] & mask, exp);
  endtask

  task automatic write_enable();
    host.frame('{ENABLE_OP}, -1, rx);
  endtask

  task automatic set_wp(input logic v);
    @(negedge i_clk);
    i_wp_n = v;
  endtask

  task automatic load(input logic id, input logic [14:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_load = '{valid: 1'b1, id_page: id, addr: a, data: d};
    @(negedge i_clk);
    i_load = '0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(negedge i_clk);
      n++;
    end
    chk({7'h00, n < 1000}, 8'h01);
  endtask

  task automatic t_reset();
    chk(status, ST_RESET_VAL);
    chk({7'h00, so_oe}, 8'h00);
    stat_is(8'hFF, 8'h00);
  endtask

  task automatic t_latch();
    host.frame('{OP_STATUS_WRITE, 8'h8C}, -1, rx);
    repeat (20) @(negedge i_clk);
    chk(status, 8'h00);
    write_enable();
    chk(status, 8'h02);
    host.frame('{OP_WRITE_DISABLE}, -1, rx);
    chk(status, 8'h00);
  endtask

  task automatic t_status_write_cmd();
    set_wp(1'b0);
    write_enable();
    host.frame('{OP_STATUS_WRITE, 8'hBF}, -1, rx);
    chk({7'h00, busy}, 8'h01);
    stat_is(8'hFD, 8'h01);
    host.frame('{OP_ARRAY_READ, 8'h00, 8'h00, 8'h00}, -1, rx);
    chk({7'h00, host.oe_seen}, 8'h00);
    wait_idle();
    chk(status, 8'h9C);
    stat_is(8'hFF, 8'h9C);
    set_wp(1'b1);
  endtask

  task automatic t_protect();
    set_wp(1'b0);
    write_enable();
    host.frame('{OP_STATUS_WRITE, 8'h00}, -1, rx);
    repeat (20) @(negedge i_clk);
    chk(status, 8'h9E);
    set_wp(1'b1);
    fork
      host.frame('{OP_STATUS_WRITE, 8'h00}, -1, rx);
      begin
        #200 set_wp(1'b0);
        #100 set_wp(1'b1);
      end
    join
    repeat (20) @(negedge i_clk);
    chk(status, 8'h9E);
    host.frame('{OP_STATUS_WRITE, 8'h00}, -1, rx);
    chk({7'h00, busy}, 8'h01);
    set_wp(1'b0);
    wait_idle();
    chk(status, 8'h10);
    set_wp(1'b1);
  endtask

  task automatic t_read();
    load(1'b0, 15'h7FFF, 8'hA5);
    load(1'b0, 15'h0000, 8'h5A);
    load(1'b0, 15'h0001, 8'hC3);
    host.frame('{OP_ARRAY_READ, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00}, -1, rx);
    chk(rx[3], 8'hA5);
    chk(rx[4], 8'h5A);
    chk(rx[5], 8'hC3);
    chk({7'h00, so_oe}, 8'h00);
  endtask

  task automatic t_idpage();
    load(1'b1, 15'h003E, 8'h11);
    load(1'b1, 15'h003F, 8'h22);
    write_enable();
    host.frame('{OP_STATUS_WRITE, 8'h40}, -1, rx);
    wait_idle();
    chk(status, 8'h50);
    host.frame('{OP_ARRAY_READ, 8'hFF, 8'hBE, 8'h00, 8'h00}, -1, rx);
    chk(rx[3], 8'h11);
    chk(rx[4], 8'h22);
    repeat (10) @(negedge i_clk);
    chk(status, 8'h10);
  endtask

  task automatic t_hold();
    host.frame('{OP_STATUS_READ, 8'h00, 8'h00}, 1, rx);
    chk(rx[1], 8'h10);
    chk(rx[2], 8'h10);
    chk({7'h00, host.hold_oe}, 8'h00);
    host.frame('{8'h02, 8'h00, 8'h00}, -1, rx);
    chk({7'h00, host.oe_seen}, 8'h00);
    chk(status, 8'h10);
  endtask

  initial begin
    i_rstn = 1'b1;
    i_wp_n = 1'b1;
    // a real falling edge so the serial-side flops take their reset
    #1 i_rstn = 1'b0;
    i_load = '0;
    repeat (10) @(negedge i_clk);
    i_rstn = 1'b1;
    @(negedge i_clk);
    t_reset();
    t_latch();
    t_status_write_cmd();
    t_protect();
    t_read();
    t_idpage();
    t_hold();
    test_done();
  end

  initial begin
    #400000;
    err_total++;
    test_done();
  end
endmodule // testbench
